// [pfs_self_access.sv]
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pfs_self_access #(
  parameter int PROG_CYCLES = pfs_pkg::PROG_CYCLES,
  parameter int PWRT_CYCLES = pfs_pkg::PWRT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_stall,
  output logic cpu_skip,
  input wire logic ser_wr_req,
  input wire logic [9:0] ser_addr,
  input wire logic [13:0] ser_data,
  input wire logic write_protect,
  output logic ser_reject
);
  typedef struct packed {
    logic [7:0] data_lo;
    logic [5:0] data_hi;
    logic [7:0] addr_lo;
    logic [1:0] addr_hi;
    logic allow;
    logic wr;
    logic rd;
    logic [1:0] seq;
    logic [1:0] rd_ph;
    pfs_pkg::pfs_state_t st;
    logic [3:0][13:0] wbuf;
    logic [23:0] pwrt_cnt;
    logic pwrt_run;
    logic stall;
    logic skip;
    logic ser_reject;
    pfs_pkg::pfs_flash_cmd_t cmd;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pfs_top_state_t;

  pfs_top_state_t s_r;
  pfs_top_state_t s_nxt;
  logic [13:0] fl_rd_data;
  logic fl_done;
  logic [9:0] word_addr;
  logic [1:0] slot;

  // (R22) ten-bit word address
  assign word_addr = {s_r.addr_hi, s_r.addr_lo};
  assign slot = s_r.addr_lo[1:0];

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign cpu_stall = s_r.stall;
  assign cpu_skip = s_r.skip;
  assign ser_reject = s_r.ser_reject;

  pfs_flash_array #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_array (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd(s_r.cmd),
    .rd_data(fl_rd_data),
    .done(fl_done)
  );

  function automatic logic [31:0] read_mux(input logic [7:0] a, input pfs_top_state_t s);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      pfs_pkg::OFF_DATA_LO: v[7:0] = s.data_lo;
      // (R1) top two bits zero
      pfs_pkg::OFF_DATA_HI: v[5:0] = s.data_hi;
      pfs_pkg::OFF_ADDR_LO: v[7:0] = s.addr_lo;
      // (R2) upper six bits zero
      pfs_pkg::OFF_ADDR_HI: v[1:0] = s.addr_hi;
      pfs_pkg::OFF_CTRL: begin
        v[pfs_pkg::CTRL_ALLOW_BIT] = s.allow;
        v[pfs_pkg::CTRL_WR_BIT] = s.wr;
        v[pfs_pkg::CTRL_RD_BIT] = s.rd;
      end
      // (R21) unlock reads zero
      pfs_pkg::OFF_UNLOCK: v = 32'h00000000;
      pfs_pkg::OFF_STATUS: begin
        v[pfs_pkg::STAT_BUSY_BIT] = (s.st != pfs_pkg::ST_IDLE);
        v[pfs_pkg::STAT_PWRT_BIT] = s.pwrt_run;
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == pfs_pkg::OFF_DATA_LO) || (a == pfs_pkg::OFF_DATA_HI) ||
           (a == pfs_pkg::OFF_ADDR_LO) || (a == pfs_pkg::OFF_ADDR_HI) ||
           (a == pfs_pkg::OFF_CTRL) || (a == pfs_pkg::OFF_UNLOCK) ||
           (a == pfs_pkg::OFF_STATUS);
  endfunction

  always_comb begin
    logic wr_fire;
    logic [3:0][13:0] nbuf;
    wr_fire = 1'b0;
    nbuf = s_r.wbuf;
    s_nxt = s_r;
    s_nxt.cmd.rd = 1'b0;
    s_nxt.cmd.blk = 1'b0;
    s_nxt.cmd.word = 1'b0;
    s_nxt.skip = 1'b0;
    s_nxt.ser_reject = 1'b0;

    // (R18) power-up hold
    if (s_r.pwrt_run) begin
      if (s_r.pwrt_cnt == 24'h000000) begin
        s_nxt.pwrt_run = 1'b0;
      end else begin
        s_nxt.pwrt_cnt = s_r.pwrt_cnt - 24'h000001;
      end
    end

    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wstb = s_axi_wstrb[0];
    end

    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_mapped(s_r.awaddr) ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
      // Any write other than the next unlock key breaks the unlock sequence.
      s_nxt.seq = 2'h0;
      if (s_r.wstb) begin
        unique case (s_r.awaddr)
          pfs_pkg::OFF_DATA_LO: s_nxt.data_lo = s_r.wdata;
          pfs_pkg::OFF_DATA_HI: s_nxt.data_hi = s_r.wdata[5:0];
          pfs_pkg::OFF_ADDR_LO: s_nxt.addr_lo = s_r.wdata;
          pfs_pkg::OFF_ADDR_HI: s_nxt.addr_hi = s_r.wdata[1:0];
          pfs_pkg::OFF_CTRL: begin
            s_nxt.allow = s_r.wdata[pfs_pkg::CTRL_ALLOW_BIT];
            // (R5) read launch set only
            if (s_r.wdata[pfs_pkg::CTRL_RD_BIT] && !s_r.rd && s_r.st == pfs_pkg::ST_IDLE) begin
              s_nxt.rd = 1'b1;
              s_nxt.rd_ph = 2'h1;
            end
            // (R23) guarded program launch
            if (s_r.wdata[pfs_pkg::CTRL_WR_BIT] && s_r.wdata[pfs_pkg::CTRL_ALLOW_BIT] &&
                s_r.seq == 2'h2 && !s_r.pwrt_run && !s_r.wr && !s_r.rd &&
                s_r.st == pfs_pkg::ST_IDLE) begin
              s_nxt.wr = 1'b1;
              s_nxt.st = pfs_pkg::ST_PREP1;
            end
          end
          pfs_pkg::OFF_UNLOCK: begin
            if (s_r.wdata == pfs_pkg::UNLOCK_KEY1) begin
              s_nxt.seq = 2'h1;
            end else if (s_r.wdata == pfs_pkg::UNLOCK_KEY2 && s_r.seq == 2'h1) begin
              s_nxt.seq = 2'h2;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = read_mux(s_axi_araddr, s_r);
      s_nxt.rresp = addr_mapped(s_axi_araddr) ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // (R6) access in second cycle
    unique case (s_r.rd_ph)
      2'h1: begin
        s_nxt.rd_ph = 2'h2;
        s_nxt.skip = 1'b1;
        s_nxt.cmd.rd = 1'b1;
        s_nxt.cmd.addr = word_addr;
      end
      2'h2: begin
        s_nxt.rd_ph = 2'h3;
      end
      2'h3: begin
        // (R7) data loaded, hardware wins
        s_nxt.data_lo = fl_rd_data[7:0];
        s_nxt.data_hi = fl_rd_data[13:8];
        s_nxt.rd = 1'b0;
        s_nxt.rd_ph = 2'h0;
      end
      default: begin
      end
    endcase

    unique case (s_r.st)
      pfs_pkg::ST_IDLE: begin
        if (ser_wr_req) begin
          // (R20) serial port honours protection
          if (write_protect || s_r.pwrt_run || s_r.wr || s_r.rd || wr_fire) begin
            s_nxt.ser_reject = 1'b1;
          end else begin
            s_nxt.cmd.word = 1'b1;
            s_nxt.cmd.addr = ser_addr;
            s_nxt.cmd.words = {{3{14'h0000}}, ser_data};
            s_nxt.st = pfs_pkg::ST_SER;
          end
        end
      end
      // (R14) two preparation cycles
      pfs_pkg::ST_PREP1: s_nxt.st = pfs_pkg::ST_PREP2;
      pfs_pkg::ST_PREP2: begin
        // (R3) allow gates the operation
        if (!s_r.allow) begin
          s_nxt.wr = 1'b0;
          s_nxt.st = pfs_pkg::ST_IDLE;
        end else begin
          // (R8) slot from low address bits
          nbuf[slot] = {s_r.data_hi, s_r.data_lo};
          s_nxt.wbuf = nbuf;
          if (slot != pfs_pkg::LAST_IN_BLOCK) begin
            // (R11) buffer load only
            s_nxt.wr = 1'b0;
            s_nxt.st = pfs_pkg::ST_IDLE;
          end else begin
            // (R12) launch row erase and program
            s_nxt.cmd.blk = 1'b1;
            s_nxt.cmd.addr = word_addr;
            s_nxt.cmd.words = nbuf;
            // (R15) stall the core
            s_nxt.stall = 1'b1;
            s_nxt.st = pfs_pkg::ST_BUSY;
          end
        end
      end
      pfs_pkg::ST_BUSY: begin
        if (fl_done) begin
          // (R4) hardware clears launch
          s_nxt.wr = 1'b0;
          // (R16) core resumes
          s_nxt.stall = 1'b0;
          s_nxt.st = pfs_pkg::ST_IDLE;
        end
      end
      pfs_pkg::ST_SER: begin
        if (fl_done) begin
          s_nxt.st = pfs_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      // (R18) allow cleared, timer armed
      s_r.allow <= 1'b0;
      s_r.pwrt_run <= 1'b1;
      s_r.pwrt_cnt <= 24'(PWRT_CYCLES - 1);
      s_r.st <= pfs_pkg::ST_IDLE;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// [pfs_pkg.sv]
// Overview of operation
// (R1) Data high byte holds six upper word bits; bits 7-6 read zero.
// (R2) Address high byte holds two upper address bits; bits 7-2 read zero.
// (R3) Program/erase allowed only while the allow bit is one.
// (R4) Program launch starts self-timed write; hardware clears it, software cannot.
// (R5) Read launch starts one-cycle read; hardware clears it, software only sets.
// (R6) Read access happens in second cycle after launch; that slot is skipped.
// (R7) Read data lands in data registers next cycle and stays there.
// (R8) Blocks are four aligned sequential words, never crossing a boundary.
// (R9) Software loads address and data, writes 55h then AAh, then launches.
// (R10) Software writes block words in ascending order, unlocking for each.
// (R11) Launch on words 0-2 only loads the buffer, finishing without stall.
// (R12) Launch on word 3 erases the sixteen-word row, programs four buffered words.
// (R13) Software reads unchanged words and reloads them so all slots are correct.
// (R14) Two preparation cycles follow a program launch; software places two no-ops.
// (R15) Instruction execution stalls about 4 ms during erase/program; clocks keep running.
// (R16) Execution resumes at third instruction after the launching instruction.
// (R17) Software repeats the block procedure for the remaining twelve words of the row.
// (R18) Allow bit clears at power-up; no write while the 64 ms power-up timer runs.
// (R19) Under code protection the controller still reads and writes plain data.
// (R20) Write-protected memory stays modifiable here but rejects serial-port writes.
// (R21) Unlock port has no storage and reads as all zeros.
// (R22) Address pair forms a 10-bit word address, 000h to 3FFh.
// (R23) Program launch takes effect only with allow set and the unlock just before.
`default_nettype none
package pfs_pkg;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 10;
  localparam int BLK_WORDS = 4;
  localparam int ROW_WORDS = 16;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;

  localparam logic [7:0] OFF_DATA_LO = 8'h00;
  localparam logic [7:0] OFF_DATA_HI = 8'h04;
  localparam logic [7:0] OFF_ADDR_LO = 8'h08;
  localparam logic [7:0] OFF_ADDR_HI = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  localparam int CTRL_ALLOW_BIT = 2;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_RD_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PWRT_BIT = 1;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [1:0] LAST_IN_BLOCK = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 4000000;
  localparam int PWRT_TIME_NS = 64000000;
  // Typical program time rounds down; power-up hold is a least time and rounds up.
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES = (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic rd;
    logic blk;
    logic word;
    logic [9:0] addr;
    logic [3:0][13:0] words;
  } pfs_flash_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP1,
    ST_PREP2,
    ST_BUSY,
    ST_SER
  } pfs_state_t;
endpackage
`default_nettype wire

// [pfs_flash_array.sv]
`timescale 1ns/1ps
`default_nettype none
module pfs_flash_array #(
  parameter int PROG_CYCLES = pfs_pkg::PROG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pfs_pkg::pfs_flash_cmd_t cmd,
  output logic [13:0] rd_data,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic blk;
    logic [23:0] cnt;
    logic [9:0] addr;
    logic [3:0][13:0] words;
    logic [13:0] rd_data;
    logic done;
  } pfs_fa_state_t;

  pfs_fa_state_t s_r;
  pfs_fa_state_t s_nxt;
  logic [13:0] mem [0:1023];
  logic commit;

  assign commit = s_r.busy && (s_r.cnt == 24'h000000);
  assign rd_data = s_r.rd_data;
  assign done = s_r.done;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    // (R19) plain data read
    if (cmd.rd) begin
      s_nxt.rd_data = mem[cmd.addr];
    end
    if (s_r.busy) begin
      s_nxt.cnt = s_r.cnt - 24'h000001;
    end
    if (commit) begin
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
    end
    if (!s_r.busy && (cmd.blk || cmd.word)) begin
      s_nxt.busy = 1'b1;
      s_nxt.blk = cmd.blk;
      s_nxt.addr = cmd.addr;
      s_nxt.words = cmd.words;
      s_nxt.cnt = 24'(PROG_CYCLES - 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // The array itself keeps its contents across reset, like real cells.
  always_ff @(posedge aclk) begin
    if (commit) begin
      if (s_r.blk) begin
        // (R12) row erase, block program
        for (int i = 0; i < pfs_pkg::ROW_WORDS; i++) begin
          mem[{s_r.addr[9:4], 4'(i)}] <= pfs_pkg::ERASED_WORD;
        end
        for (int j = 0; j < pfs_pkg::BLK_WORDS; j++) begin
          mem[{s_r.addr[9:2], 2'(j)}] <= s_r.words[j];
        end
      end else begin
        mem[s_r.addr] <= s_r.words[0];
      end
    end
  end
endmodule
`default_nettype wire

// [pfs_self_access_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pfs_self_access_properties #(
  parameter int PROG_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_stall,
  input wire logic cpu_skip,
  input wire logic ser_reject
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [23:0] stall_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_stall) begin
      stall_cnt_r <= 24'h0;
    end else begin
      stall_cnt_r <= stall_cnt_r + 24'h1;
    end
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_one_write: assert property (!(s_axi_bvalid && s_axi_awready)) else $error("write accepted while answering");
  a_one_read: assert property (!(s_axi_rvalid && s_axi_arready)) else $error("read accepted while answering");
  a_skip_pulse: assert property (cpu_skip |=> !cpu_skip) else $error("skip longer than one cycle");
  a_skip_free: assert property (cpu_skip |-> !cpu_stall) else $error("skip during stall");
  a_stall_bound: assert property (stall_cnt_r <= PROG_CYCLES + 4) else $error("stall too long");
  a_reject_pulse: assert property (ser_reject |=> !ser_reject) else $error("reject longer than one cycle");
endmodule
`default_nettype wire

// [pfs_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pfs_cpu_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, araddr, wdata} = 48'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic prog(input logic [9:0] a, input logic [13:0] w);
    logic [1:0] r;
    wr(8'h08, a[7:0], r);
    wr(8'h0C, {6'h0, a[9:8]}, r);
    wr(8'h00, w[7:0], r);
    wr(8'h04, {2'h0, w[13:8]}, r);
    wr(8'h14, 8'h55, r);
    wr(8'h14, 8'hAA, r);
    wr(8'h10, 8'h06, r);
    repeat (2) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic stall, skip, ser_req, wprot, ser_rej;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [9:0] ser_addr;
  logic [13:0] ser_data;
  int n_errors = 0, tests_run = 0, cyc = 0, n_stall = 0, n_skip = 0, n_rej = 0;
  pfs_self_access #(.PROG_CYCLES(40), .PWRT_CYCLES(40)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_stall(stall), .cpu_skip(skip), .ser_wr_req(ser_req), .ser_addr(ser_addr),
    .ser_data(ser_data), .write_protect(wprot), .ser_reject(ser_rej));
  pfs_cpu_model u_cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  // The run needs about seven hundred cycles; the ceiling leaves ample margin.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_stall <= n_stall + int'(stall);
    n_skip <= n_skip + int'(skip);
    n_rej <= n_rej + int'(ser_rej);
    if (cyc == 8000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_cpu.rd(a, d, r);
    chk("register read", e, d);
    chk("read response", 32'h0, r);
  endtask
  task automatic wait_bit(input logic [7:0] a, input logic [31:0] m);
    do u_cpu.rd(a, d, r); while ((d & m) != 32'h0);
  endtask
  task automatic fread(input logic [9:0] a, input logic [13:0] e);
    int k;
    k = n_skip;
    u_cpu.wr(8'h08, a[7:0], r);
    u_cpu.wr(8'h0C, {6'h0, a[9:8]}, r);
    u_cpu.wr(8'h10, 8'h01, r);
    wait_bit(8'h10, 32'h1);
    chk("skip count", k + 1, n_skip);
    rdc(8'h00, {24'h0, e[7:0]});
    rdc(8'h04, {26'h0, e[13:8]});
  endtask
  task automatic t_regs();
    int k;
    k = n_stall;
    rdc(8'h10, 32'h0);
    rdc(8'h18, 32'h2);
    u_cpu.wr(8'h08, 8'hFF, r);
    u_cpu.wr(8'h14, 8'h55, r);
    u_cpu.wr(8'h14, 8'hAA, r);
    u_cpu.wr(8'h10, 8'h06, r);
    repeat (4) @(posedge aclk);
    chk("stall in power-up", k, n_stall);
    u_cpu.wr(8'h04, 8'hFF, r);
    rdc(8'h04, 32'h3F);
    u_cpu.wr(8'h0C, 8'hFF, r);
    rdc(8'h0C, 32'h3);
    rdc(8'h14, 32'h0);
    u_cpu.wr(8'h1C, 8'h01, r);
    chk("unmapped response", 32'h2, r);
    u_cpu.rd(8'h1C, d, r);
    chk("unmapped read response", 32'h2, r);
    chk("unmapped read data", 32'h0, d);
    wait_bit(8'h18, 32'h2);
  endtask
  task automatic t_lock();
    int k;
    k = n_stall;
    u_cpu.wr(8'h10, 8'h06, r);
    u_cpu.wr(8'h14, 8'h55, r);
    u_cpu.wr(8'h14, 8'hAA, r);
    u_cpu.wr(8'h10, 8'h02, r);
    repeat (4) @(posedge aclk);
    chk("stall when locked", k, n_stall);
    rdc(8'h10, 32'h0);
  endtask
  task automatic t_block();
    int k;
    for (int i = 0; i < 3; i++) begin
      k = n_stall;
      u_cpu.prog(10'h3FC + 10'(i), 14'h1230 + 14'(i));
      repeat (4) @(posedge aclk);
      chk("buffer load stall", k, n_stall);
      rdc(8'h10, 32'h4);
    end
    k = n_stall;
    u_cpu.prog(10'h3FF, 14'h2ABC);
    u_cpu.wr(8'h10, 8'h04, r);
    rdc(8'h10, 32'h6);
    wait_bit(8'h10, 32'h2);
    chk("stall length", 32'h1, 32'(n_stall - k >= 40 && n_stall - k <= 44));
    for (int i = 0; i < 4; i++) fread(10'h3FC + 10'(i), (i == 3) ? 14'h2ABC : 14'h1230 + 14'(i));
    fread(10'h3F0, 14'h3FFF);
  endtask
  task automatic t_serial();
    int k;
    k = n_rej;
    @(posedge aclk);
    {wprot, ser_req} <= 2'h3;
    ser_addr <= 10'h3F1;
    ser_data <= 14'h0155;
    @(posedge aclk);
    ser_req <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("serial reject", k + 1, n_rej);
    {wprot, ser_req} <= 2'h1;
    @(posedge aclk);
    ser_req <= 1'h0;
    wait_bit(8'h18, 32'h1);
    chk("serial accept", k + 1, n_rej);
    fread(10'h3F1, 14'h0155);
  endtask
  // Reads a word it keeps, then sends it back through the buffer unchanged.
  task automatic reload(input logic [9:0] a, input logic [13:0] e);
    fread(a, e);
    u_cpu.wr(8'h14, 8'h55, r);
    u_cpu.wr(8'h14, 8'hAA, r);
    u_cpu.wr(8'h10, 8'h06, r);
    repeat (2) @(posedge aclk);
    wait_bit(8'h10, 32'h2);
  endtask
  task automatic t_reload();
    u_cpu.prog(10'h3F0, 14'h0AA5);
    reload(10'h3F1, 14'h0155);
    reload(10'h3F2, 14'h3FFF);
    reload(10'h3F3, 14'h3FFF);
    fread(10'h3F0, 14'h0AA5);
    fread(10'h3F1, 14'h0155);
    fread(10'h3FC, 14'h3FFF);
  endtask
  initial begin
    aresetn = 1'h0;
    {wprot, ser_req, ser_addr, ser_data} = 26'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_lock();
    t_block();
    t_serial();
    t_reload();
    end_of_test();
  end
endmodule
bind pfs_self_access pfs_self_access_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cpu_stall(cpu_stall), .cpu_skip(cpu_skip), .ser_reject(ser_reject));
`default_nettype wire
